// *** rtl/osc_calib.sv ***
// Chosen here: register access over APB.
`timescale 1ns/1ps
// Operation
// - Two-bit field selects oscillator to measure
// - Gate source bit picks reference or external
// - Writing start one begins a measurement
// - Start bit self-clears when measurement done
// - Window length counts down to one
// - Count divided fast clock during window
// - Result low half readable, read only
// - Result high half readable, read only
module osc_calib
    import calib_pkg::*;
#(
    parameter int DIV_WIDTH = 2,
    parameter logic [DIV_WIDTH-1:0] DIV_RATIO_M1 = '0
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire osc_in_t OSC_I,
    output logic BUSY_O
);

    // Divider wider than 16 bits would make one tick outlast any window
    if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin : g_bad_div_width
        $error("DIV_WIDTH out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers: oscillators are asynchronous to CLK_I
    osc_in_t sync1_ff;
    osc_in_t sync2_ff;
    osc_in_t sync3_ff;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= OSC_I;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    calib_ctrl_t ctrl_ff;
    logic [15:0] window_ff;
    logic [31:0] result_ff;
    calib_state_t state_ff;
    logic [15:0] remain_ff;
    logic [31:0] cycles_ff;
    logic [DIV_WIDTH-1:0] div_ff;

    logic access;
    logic wr;
    logic [ADDR_BITS-1:0] addr;
    logic mapped;
    logic start_req;
    logic ref_sel;
    logic ref_rise;
    logic gate_rise;
    logic div_tick;
    logic done;

    assign access = PSEL_I && PENABLE_I;
    assign wr = access && PWRITE_I;
    assign addr = PADDR_I[ADDR_BITS-1:0];
    assign mapped = (PADDR_I[31:ADDR_BITS] == '0) && (addr == CONTROL_ADDR || addr == WINDOW_ADDR
        || addr == RESULT_LOW_ADDR || addr == RESULT_HIGH_ADDR);
    // Start taken only when idle; a second start mid-window is ignored
    assign start_req = wr && addr == CONTROL_ADDR && PSTRB_I[0] && PWDATA_I[START_BIT]
        && state_ff == ST_IDLE && PADDR_I[31:ADDR_BITS] == '0;

    ////////////////////////////////////////////////////////////////////////////
    // Reference and gate selection
    always_comb begin
        case (ctrl_ff.src)
            SRC_RC_SLOW: ref_sel = sync2_ff.rc_osc_slow;
            SRC_RC_FAST: ref_sel = sync2_ff.rc_osc_fast;
            SRC_XTAL_SLOW: ref_sel = sync2_ff.crystal_osc_slow;
            SRC_RC_EXT: ref_sel = sync2_ff.rc_extended_osc;
            default: ref_sel = 1'b0;
        endcase
    end

    logic ref_prev;
    always_comb begin
        case (ctrl_ff.src)
            SRC_RC_SLOW: ref_prev = sync3_ff.rc_osc_slow;
            SRC_RC_FAST: ref_prev = sync3_ff.rc_osc_fast;
            SRC_XTAL_SLOW: ref_prev = sync3_ff.crystal_osc_slow;
            SRC_RC_EXT: ref_prev = sync3_ff.rc_extended_osc;
            default: ref_prev = 1'b0;
        endcase
    end

    assign ref_rise = ref_sel && !ref_prev;
    assign gate_rise = sync2_ff.ext_gate && !sync3_ff.ext_gate;
    // Window advances on reference edges or external gate edges
    logic win_tick;
    assign win_tick = ctrl_ff.gate_ext ? gate_rise : ref_rise;
    assign done = state_ff == ST_MEASURE && win_tick && remain_ff <= WINDOW_END;

    ////////////////////////////////////////////////////////////////////////////
    // Fast clock divider: CLK_I stands in for the fast system clock
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || start_req) begin
            div_ff <= '0;
        end else if (div_ff == DIV_RATIO_M1) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign div_tick = div_ff == DIV_RATIO_M1;

    ////////////////////////////////////////////////////////////////////////////
    // Measurement sequencer
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (start_req) begin
                        state_ff <= ST_MEASURE;
                    end
                end
                ST_MEASURE: begin
                    if (done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            remain_ff <= WINDOW_RESET;
        end else if (start_req) begin
            remain_ff <= window_ff;
        end else if (state_ff == ST_MEASURE && win_tick) begin
            remain_ff <= remain_ff - 16'h0001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I || start_req) begin
            cycles_ff <= RESULT_RESET;
        end else if (state_ff == ST_MEASURE && div_tick) begin
            cycles_ff <= cycles_ff + 32'h00000001;
        end
    end

    // Result frozen between measurements
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            result_ff <= RESULT_RESET;
        end else if (done) begin
            result_ff <= (div_tick) ? cycles_ff + 32'h00000001 : cycles_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ctrl_ff <= calib_ctrl_t'(CONTROL_RESET[3:0]);
        end else begin
            if (wr && addr == CONTROL_ADDR && PSTRB_I[0] && PADDR_I[31:ADDR_BITS] == '0) begin
                ctrl_ff.src <= clk_src_t'(PWDATA_I[SRC_MSB:SRC_LSB]);
                ctrl_ff.gate_ext <= PWDATA_I[GATE_BIT];
            end
            if (start_req) begin
                ctrl_ff.start <= 1'b1;
            end else if (done) begin
                ctrl_ff.start <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            window_ff <= WINDOW_RESET;
        end else if (wr && addr == WINDOW_ADDR && PADDR_I[31:ADDR_BITS] == '0) begin
            if (PSTRB_I[0]) begin
                window_ff[7:0] <= PWDATA_I[7:0];
            end
            if (PSTRB_I[1]) begin
                window_ff[15:8] <= PWDATA_I[15:8];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PRDATA_O <= '0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (addr)
                CONTROL_ADDR: PRDATA_O <= {28'h0000000, ctrl_ff};
                WINDOW_ADDR: PRDATA_O <= {16'h0000, window_ff};
                RESULT_LOW_ADDR: PRDATA_O <= {16'h0000, result_ff[15:0]};
                RESULT_HIGH_ADDR: PRDATA_O <= {16'h0000, result_ff[31:16]};
                default: PRDATA_O <= '0;
            endcase
        end
    end

    assign PREADY_O = 1'b1;
    // Result registers read only; writes there are errors
    assign PSLVERR_O = access && (!mapped || (PWRITE_I && (addr == RESULT_LOW_ADDR
        || addr == RESULT_HIGH_ADDR)));
    assign BUSY_O = state_ff == ST_MEASURE;

endmodule // osc_calib

// *** rtl/calib_pkg.sv ***
package calib_pkg;
    // Register indices (printed offsets are halfword spaced, byte address = 4 * index)
    localparam logic [31:0] CALIB_BASE_IDX = 32'h50001600;
    localparam logic [31:0] CALIB_CONTROL_IDX = 32'h50001600;
    localparam logic [31:0] CALIB_WINDOW_IDX = 32'h50001602;
    localparam logic [31:0] CALIB_RESULT_LOW_IDX = 32'h50001604;
    localparam logic [31:0] CALIB_RESULT_HIGH_IDX = 32'h50001606;
    // Decode uses the low bits of the byte address
    localparam int ADDR_BITS = 5;
    localparam logic [ADDR_BITS-1:0] CONTROL_ADDR = 5'h00;
    localparam logic [ADDR_BITS-1:0] WINDOW_ADDR = 5'h08;
    localparam logic [ADDR_BITS-1:0] RESULT_LOW_ADDR = 5'h10;
    localparam logic [ADDR_BITS-1:0] RESULT_HIGH_ADDR = 5'h18;
    // Control fields
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 1;
    localparam int START_BIT = 2;
    localparam int GATE_BIT = 3;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_RESET = 16'h0000;
    localparam logic [31:0] RESULT_RESET = 32'h00000000;
    localparam logic [15:0] WINDOW_END = 16'h0001;
    localparam logic [1:0] DIV_RESET = 2'h0;

    typedef enum logic [1:0] {
        SRC_RC_SLOW = 2'h0,
        SRC_RC_FAST = 2'h1,
        SRC_XTAL_SLOW = 2'h2,
        SRC_RC_EXT = 2'h3
    } clk_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_MEASURE = 2'b10
    } calib_state_t;

    typedef struct packed {
        logic gate_ext;
        logic start;
        clk_src_t src;
    } calib_ctrl_t;

    typedef struct packed {
        logic rc_osc_slow;
        logic rc_osc_fast;
        logic crystal_osc_slow;
        logic rc_extended_osc;
        logic ext_gate;
    } osc_in_t;
endpackage

// *** test/osc_calib_monitor.sv ***
`timescale 1ns/1ps
module osc_calib_monitor (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PSLVERR_O,
    input wire logic BUSY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    ////////////////////////////////////////////////////////////
    wire acc = PSEL_I && PENABLE_I && PWRITE_I;
    wire go = acc && PADDR_I[4:0] == 5'h00 && PWDATA_I[2];
    wire stop = acc && PADDR_I[4:0] == 5'h00 && !PWDATA_I[2];
    ////////////////////////////////////////////////////////////
    AST_START: assert property (go && !BUSY_O |=> BUSY_O)
        else $error("start write ignored");
    AST_NOSTART: assert property (stop && !BUSY_O |=> !BUSY_O)
        else $error("busy without start");
    // Busy must never rise on its own
    AST_CAUSE: assert property ($rose(BUSY_O) |-> $past(go))
        else $error("busy rose without start write");
    AST_RO_LOW: assert property (acc && PADDR_I[4:0] == 5'h10 |-> PSLVERR_O)
        else $error("low result write accepted");
    AST_RO_HIGH: assert property (acc && PADDR_I[4:0] == 5'h18 |-> PSLVERR_O)
        else $error("high result write accepted");
    AST_UPPER: assert property (PRDATA_O[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_RESET: assert property ($rose(RST_B_I) |-> !BUSY_O && PRDATA_O == 32'h00000000)
        else $error("state not cleared by reset");
    // Read data is loaded at setup, so it mirrors busy of that cycle
    AST_MIRROR: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I[4:0] == 5'h00
        |=> PRDATA_O[2] == $past(BUSY_O))
        else $error("start bit differs from busy");
endmodule // osc_calib_monitor

bind osc_calib osc_calib_monitor u_mon (.CLK_I, .RST_B_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PADDR_I, .PWDATA_I, .PRDATA_O, .PSLVERR_O, .BUSY_O);

// *** test/osc_model.sv ***
`timescale 1ns/1ps
module osc_model
    import calib_pkg::*;
(
    output osc_in_t osc_o
);
    // Free running; edges on falling clock so sync sampling never races
    logic slow_q = 1'b0;
    logic fast_q = 1'b0;
    logic xtal_q = 1'b0;
    logic ext_q = 1'b0;
    logic gate_q = 1'b0;
    always #400 slow_q = ~slow_q;
    always #600 fast_q = ~fast_q;
    always #900 xtal_q = ~xtal_q;
    always #1300 ext_q = ~ext_q;
    always #1800 gate_q = ~gate_q;
    // One driver for the whole bundle
    assign osc_o = {slow_q, fast_q, xtal_q, ext_q, gate_q};
endmodule // osc_model

// *** test/osc_calib_test.sv ***
`timescale 1ns/1ps
module osc_calib_test
    import calib_pkg::*;
;
    logic clk, rst_b, psel, pen, pwr, pready, pslverr, busy, er;
    logic [31:0] paddr, pwdata, prdata, rd;
    osc_in_t osc;
    int err_count, comparisons;
    osc_calib uut (.CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .OSC_I(osc), .BUSY_O(busy));
    osc_model osc_src (.osc_o(osc));
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////
    task results;
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Range compare; exact when lo equals hi
    task chk(string n, logic [31:0] lo, logic [31:0] hi, logic [31:0] g);
        comparisons++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            $display("Error %s expected %h..%h seen %h", n, lo, hi, g);
            err_count++;
        end
    endtask
    task xfer(logic w, logic [4:0] a, logic [31:0] d);
        int n;
        psel <= 1;
        pen <= 0;
        pwr <= w;
        paddr <= {27'h0, a};
        pwdata <= d;
        @(posedge clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    // Phase of the first edge is unknown, hence a window of one period
    task run(logic [3:0] c, logic [15:0] w, int p);
        int n;
        logic [31:0] lo;
        xfer(1, 5'h08, {16'h0, w});
        xfer(1, 5'h00, {28'h0, c});
        n = 0;
        while (busy !== 1'b0 && n < 80000) begin
            @(posedge clk);
            n++;
        end
        if (n == 80000) begin
            err_count++;
            results();
        end
        xfer(0, 5'h00, 0);
        chk("start", 0, 0, {31'h0, rd[2]});
        xfer(0, 5'h10, 0);
        lo = rd;
        xfer(0, 5'h18, 0);
        chk("result", (w - 1) * p, w * p + 2, {rd[15:0], lo[15:0]});
    endtask
    ////////////////////////////////////////////////////////////
    task reset_values;
        for (int a = 0; a < 32; a += 8) begin
            xfer(0, a[4:0], 0);
            chk("reset", 0, 0, rd);
        end
    endtask
    task sources;
        int per[4] = '{8, 12, 18, 26};
        for (int s = 0; s < 4; s++) run(4'h4 | s[3:0], 16'd5, per[s]);
    endtask
    task refused;
        logic [31:0] k;
        xfer(1, 5'h00, 0);
        chk("busy", 0, 0, {31'h0, busy});
        xfer(0, 5'h10, 0);
        k = rd;
        xfer(1, 5'h10, 32'hffff);
        chk("err", 1, 1, {31'h0, er});
        xfer(1, 5'h18, 32'hffff);
        chk("err", 1, 1, {31'h0, er});
        xfer(0, 5'h10, 0);
        chk("hold", k, k, rd);
    endtask
    initial begin
        psel = 0;
        pen = 0;
        pwr = 0;
        paddr = 0;
        pwdata = 0;
        rst_b = 0;
        err_count = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        reset_values();
        sources();
        run(4'hc, 16'd5, 36);
        refused();
        run(4'hc, 16'd1900, 36);
        results();
    end
endmodule // osc_calib_test
